// ---- inc/motor_speed_cmd_defines.svh ----
// Register offsets, field positions, reset values and timing for the speed command front end.
`ifndef MOTOR_SPEED_CMD_DEFINES_SVH
`define MOTOR_SPEED_CMD_DEFINES_SVH

// Register byte offsets.
`define MSC_OFS_CTRL 8'h00
`define MSC_OFS_MOTOR_CMD 8'h04
`define MSC_OFS_START_THR 8'h08
`define MSC_OFS_STOP_THR 8'h0c
`define MSC_OFS_GAIN 8'h10
`define MSC_OFS_RETRY 8'h14
`define MSC_OFS_PG_STEP 8'h18
`define MSC_OFS_STATUS 8'h1c
`define MSC_OFS_TARGET 8'h20
`define MSC_OFS_MEAS 8'h24
`define MSC_OFS_MIN_SPEED 8'h28

// Control register fields.
`define MSC_CTRL_MODE_LSB 0
`define MSC_CTRL_SENSE_LSB 2
`define MSC_CTRL_PG_ALWAYS_BIT 4
`define MSC_CTRL_CUSTOM_BIT 6
// Motor command register fields.
`define MSC_CMD_RUN_BIT 16
`define MSC_CMD_CLEAR_BIT 17
// Retry register fields.
`define MSC_RETRY_CNT_LSB 0
`define MSC_RETRY_INT_LSB 8

// Reset values.
`define MSC_RST_CTRL 6'h00
`define MSC_RST_START_THR 16'h0000
`define MSC_RST_STOP_THR 16'h0000
`define MSC_RST_GAIN 16'h0000
`define MSC_RST_MIN_SPEED 14'h0000
`define MSC_RST_PG_STEP 14'h0000

// Speed scaling.
`define MSC_SPEED_FULL 16'h3fff
`define MSC_GAIN_FRAC 12
`define MSC_DIFF_SCALE 5
`define MSC_PG_HALF_SHIFT 6

// Timing.
`define MSC_CLK_HZ 50000000
`define MSC_REFRESH_MS 10
`define MSC_TIMEOUT_MS 200
`define MSC_FREQ_UNITS_PER_HZ 10
`define MSC_DUTY_FULL 1000
`define MSC_DIV_STEPS 6'd40

`endif

// ---- inc/motor_speed_cmd_pkg.sv ----
// Types shared by the speed command front end.
package motor_speed_cmd_pkg;

  typedef enum logic [1:0] {
    MODE_SERIAL = 2'h0,
    MODE_ANALOG = 2'h1,
    MODE_FREQ = 2'h2,
    MODE_DUTY = 2'h3
  } cmd_mode_e;

  typedef enum logic [1:0] {
    SENSE_LESS = 2'h0,
    SENSE_HALL = 2'h1,
    SENSE_HYBRID = 2'h2
  } sense_mode_e;

  typedef enum logic [2:0] {
    DIV_IDLE = 3'b001,
    DIV_FREQ = 3'b010,
    DIV_DUTY = 3'b100
  } div_state_e;

  typedef struct packed {
    logic custom;
    logic pg_always;
    logic [1:0] sense;
    logic [1:0] mode;
  } ctrl_s;

  typedef struct packed {
    logic [15:0] interval;
    logic [7:0] count;
  } retry_s;

endpackage : motor_speed_cmd_pkg

// ---- verilog/motor_speed_command_input.sv ----
// Speed command front end: command sources, fault restart and position pulse output.
//
// Summary of operation
// - Serial mode: commands set run and signed target.
// - Serial mode: fault holds until host clears it.
// - Direction input high makes target speed negative.
// - Input above start threshold requests motor start.
// - Input below stop threshold requests motor stop.
// - At maximum input, target saturates at full scale.
// - Linear map from minimum speed, 12-bit fraction gain.
// - Frequency measured and compared in 0.1 Hz units.
// - Duty measured and compared in 0.1 percent units.
// - Non-serial modes retry after fault; zero disables.
// - Mode change by command acts at once.
// - Forcing serial mode keeps run state and target.
// - Pulse output always in Hall or hybrid or with pg_always; otherwise sensorless only running.
// - Pulse step from angle setting; zero disables output.
// - Pulse output updated once per PWM cycle.
// - Step up to 16383; 512 is one period per cycle.
// - Power-of-two step aligns transitions to rotor angle.
// - Custom bit refreshes measurements every 10 ms.
// - Measurement covers 5 to 5000 Hz, 1-99 percent.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "motor_speed_cmd_defines.svh"

module motor_speed_command_input #(
  parameter int REFRESH_CYCLES = `MSC_CLK_HZ / 1000 * `MSC_REFRESH_MS,
  parameter int TIMEOUT_CYCLES = `MSC_CLK_HZ / 1000 * `MSC_TIMEOUT_MS,
  parameter int ADC_W = 12
) (
  input wire logic pclk, // System clock, 50 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  input wire logic pulse_speed_cmd_in, // Frequency or duty command pin.
  input wire logic dir_in, // Direction pin, high for reverse.
  input wire logic [ADC_W-1:0] analog_sample_value, // Analog command sample.
  input wire logic pwm_tick, // One pulse per PWM cycle.
  input wire logic fault_in, // Drive fault event.
  input wire logic [15:0] rotor_angle, // Electrical rotor angle.
  output logic motor_run, // Run request to the motor control.
  output logic signed [15:0] target_speed_value, // Signed target speed.
  output logic motor_fault, // Fault status.
  output logic position_pulse_out // Rotor position pulse train.
);

  // ==========================================================================
  // Register bus
  // ==========================================================================
  motor_speed_cmd_pkg::ctrl_s ctrl_r;
  motor_speed_cmd_pkg::retry_s retry_r;
  logic [15:0] start_thr_r;
  logic [15:0] stop_thr_r;
  logic [15:0] gain_r;
  logic [13:0] min_speed_r;
  logic [13:0] pg_step_r;
  logic [15:0] freq_meas_r;
  logic [15:0] duty_meas_r;
  logic [15:0] freq_snap_r;
  logic [15:0] duty_snap_r;
  logic run_r;
  logic signed [15:0] target_r;
  logic fault_r;
  logic [7:0] retry_left_r;
  logic [15:0] retry_wait_r;
  logic pg_r;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  logic wr_en;
  logic mapped;
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign mapped = addr_hit(paddr, `MSC_OFS_CTRL) | addr_hit(paddr, `MSC_OFS_MOTOR_CMD) |
                  addr_hit(paddr, `MSC_OFS_START_THR) | addr_hit(paddr, `MSC_OFS_STOP_THR) |
                  addr_hit(paddr, `MSC_OFS_GAIN) | addr_hit(paddr, `MSC_OFS_RETRY) |
                  addr_hit(paddr, `MSC_OFS_PG_STEP) | addr_hit(paddr, `MSC_OFS_STATUS) |
                  addr_hit(paddr, `MSC_OFS_TARGET) | addr_hit(paddr, `MSC_OFS_MEAS) |
                  addr_hit(paddr, `MSC_OFS_MIN_SPEED);
  assign pslverr = psel & penable & ~mapped;

  logic cmd_wr;
  logic ctrl_wr;
  logic retry_wr;
  assign cmd_wr = wr_en & addr_hit(paddr, `MSC_OFS_MOTOR_CMD);
  assign ctrl_wr = wr_en & addr_hit(paddr, `MSC_OFS_CTRL);
  assign retry_wr = wr_en & addr_hit(paddr, `MSC_OFS_RETRY);

  // The mode field takes effect on the write edge itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `MSC_RST_CTRL;
    end else if (ctrl_wr) begin
      ctrl_r.mode <= pwdata[`MSC_CTRL_MODE_LSB +: 2];
      ctrl_r.sense <= pwdata[`MSC_CTRL_SENSE_LSB +: 2];
      ctrl_r.pg_always <= pwdata[`MSC_CTRL_PG_ALWAYS_BIT];
      ctrl_r.custom <= pwdata[`MSC_CTRL_CUSTOM_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_thr_r <= `MSC_RST_START_THR;
      stop_thr_r <= `MSC_RST_STOP_THR;
      gain_r <= `MSC_RST_GAIN;
      min_speed_r <= `MSC_RST_MIN_SPEED;
      pg_step_r <= `MSC_RST_PG_STEP;
      retry_r <= '0;
    end else if (wr_en) begin
      if (addr_hit(paddr, `MSC_OFS_START_THR)) start_thr_r <= pwdata[15:0];
      if (addr_hit(paddr, `MSC_OFS_STOP_THR)) stop_thr_r <= pwdata[15:0];
      if (addr_hit(paddr, `MSC_OFS_GAIN)) gain_r <= pwdata[15:0];
      if (addr_hit(paddr, `MSC_OFS_MIN_SPEED)) min_speed_r <= pwdata[13:0];
      if (addr_hit(paddr, `MSC_OFS_PG_STEP)) pg_step_r <= pwdata[13:0];
      if (retry_wr) begin
        retry_r.count <= pwdata[`MSC_RETRY_CNT_LSB +: 8];
        retry_r.interval <= pwdata[`MSC_RETRY_INT_LSB +: 16];
      end
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    if (psel & ~pwrite) begin
      case (paddr)
        `MSC_OFS_CTRL: prdata = {25'h0, ctrl_r.custom, 1'b0, ctrl_r.pg_always, ctrl_r.sense,
                                 ctrl_r.mode};
        `MSC_OFS_START_THR: prdata = {16'h0, start_thr_r};
        `MSC_OFS_STOP_THR: prdata = {16'h0, stop_thr_r};
        `MSC_OFS_GAIN: prdata = {16'h0, gain_r};
        `MSC_OFS_RETRY: prdata = {8'h0, retry_r.interval, retry_r.count};
        `MSC_OFS_PG_STEP: prdata = {18'h0, pg_step_r};
        `MSC_OFS_STATUS: prdata = {16'h0, retry_left_r, 4'h0, pg_r, fault_r, fault_r, run_r};
        `MSC_OFS_TARGET: prdata = {{16{target_r[15]}}, target_r};
        `MSC_OFS_MEAS: prdata = {duty_snap_r, freq_snap_r};
        `MSC_OFS_MIN_SPEED: prdata = {18'h0, min_speed_r};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Input period and high-time capture
  // ==========================================================================
  logic pin_d_r;
  logic [31:0] per_cnt_r;
  logic [31:0] high_cnt_r;
  logic [31:0] per_cap_r;
  logic [31:0] high_cap_r;
  logic cap_new_r;
  logic rise;
  assign rise = pulse_speed_cmd_in & ~pin_d_r;

  // No edge for longer than the timeout means the input sits below 5 Hz.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_d_r <= 1'b0;
      per_cnt_r <= 32'h0;
      high_cnt_r <= 32'h0;
      per_cap_r <= 32'h0;
      high_cap_r <= 32'h0;
      cap_new_r <= 1'b0;
    end else begin
      pin_d_r <= pulse_speed_cmd_in;
      cap_new_r <= 1'b0;
      if (rise) begin
        per_cap_r <= per_cnt_r + 32'h1;
        high_cap_r <= high_cnt_r;
        cap_new_r <= 1'b1;
        per_cnt_r <= 32'h0;
        high_cnt_r <= 32'h1;
      end else if (per_cnt_r >= 32'(TIMEOUT_CYCLES)) begin
        per_cap_r <= 32'h0;
        high_cap_r <= 32'h0;
        cap_new_r <= 1'b1;
        per_cnt_r <= 32'h0;
        high_cnt_r <= 32'h0;
      end else begin
        per_cnt_r <= per_cnt_r + 32'h1;
        if (pulse_speed_cmd_in) high_cnt_r <= high_cnt_r + 32'h1;
      end
    end
  end

  // ==========================================================================
  // Serial divider: frequency in 0.1 Hz, then duty in 0.1 percent
  // ==========================================================================
  motor_speed_cmd_pkg::div_state_e div_st_r;
  logic [39:0] dvd_r;
  logic [31:0] dvs_r;
  logic [40:0] rem_r;
  logic [5:0] step_r;
  logic [40:0] rem_sh;
  assign rem_sh = {rem_r[39:0], dvd_r[39]};

  localparam logic [39:0] FREQ_NUM = 40'(`MSC_CLK_HZ * `MSC_FREQ_UNITS_PER_HZ);

  function automatic logic [15:0] sat16(input logic [39:0] q);
    sat16 = (q[39:16] != 24'h0) ? 16'hffff : q[15:0];
  endfunction : sat16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_st_r <= motor_speed_cmd_pkg::DIV_IDLE;
      dvd_r <= 40'h0;
      dvs_r <= 32'h0;
      rem_r <= 41'h0;
      step_r <= 6'h0;
      freq_meas_r <= 16'h0;
      duty_meas_r <= 16'h0;
    end else begin
      case (div_st_r)
        motor_speed_cmd_pkg::DIV_IDLE: begin
          if (cap_new_r) begin
            if (per_cap_r == 32'h0) begin
              freq_meas_r <= 16'h0;
              duty_meas_r <= 16'h0;
            end else begin
              dvd_r <= FREQ_NUM;
              dvs_r <= per_cap_r;
              rem_r <= 41'h0;
              step_r <= `MSC_DIV_STEPS;
              div_st_r <= motor_speed_cmd_pkg::DIV_FREQ;
            end
          end
        end
        motor_speed_cmd_pkg::DIV_FREQ, motor_speed_cmd_pkg::DIV_DUTY: begin
          if (step_r != 6'h0) begin
            if (rem_sh >= {9'h0, dvs_r}) begin
              rem_r <= rem_sh - {9'h0, dvs_r};
              dvd_r <= {dvd_r[38:0], 1'b1};
            end else begin
              rem_r <= rem_sh;
              dvd_r <= {dvd_r[38:0], 1'b0};
            end
            step_r <= step_r - 6'h1;
          end else if (div_st_r == motor_speed_cmd_pkg::DIV_FREQ) begin
            freq_meas_r <= sat16(dvd_r);
            dvd_r <= 40'(high_cap_r) * 40'(`MSC_DUTY_FULL);
            rem_r <= 41'h0;
            step_r <= `MSC_DIV_STEPS;
            div_st_r <= motor_speed_cmd_pkg::DIV_DUTY;
          end else begin
            duty_meas_r <= sat16(dvd_r);
            div_st_r <= motor_speed_cmd_pkg::DIV_IDLE;
          end
        end
        default: div_st_r <= motor_speed_cmd_pkg::DIV_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Custom-mapping snapshots
  // ==========================================================================
  logic [31:0] refresh_cnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt_r <= 32'h0;
      freq_snap_r <= 16'h0;
      duty_snap_r <= 16'h0;
    end else if (!ctrl_r.custom) begin
      refresh_cnt_r <= 32'h0;
    end else if (refresh_cnt_r >= 32'(REFRESH_CYCLES - 1)) begin
      refresh_cnt_r <= 32'h0;
      freq_snap_r <= freq_meas_r;
      duty_snap_r <= duty_meas_r;
    end else begin
      refresh_cnt_r <= refresh_cnt_r + 32'h1;
    end
  end

  // ==========================================================================
  // Command mapping
  // ==========================================================================
  logic [15:0] cmd_level;
  logic [16:0] cmd_diff;
  logic [36:0] map_prod;
  logic [24:0] map_speed;
  logic [13:0] mag;
  logic signed [15:0] mapped_target;
  logic linear_mode;

  always_comb begin
    case (ctrl_r.mode)
      motor_speed_cmd_pkg::MODE_ANALOG: cmd_level = 16'(analog_sample_value);
      motor_speed_cmd_pkg::MODE_FREQ: cmd_level = freq_meas_r;
      motor_speed_cmd_pkg::MODE_DUTY: cmd_level = duty_meas_r;
      default: cmd_level = 16'h0;
    endcase
  end

  assign linear_mode = (ctrl_r.mode == motor_speed_cmd_pkg::MODE_ANALOG) |
                       ((ctrl_r.mode != motor_speed_cmd_pkg::MODE_SERIAL) & ~ctrl_r.custom);
  assign cmd_diff = {1'b0, cmd_level} - {1'b0, start_thr_r};
  assign map_prod = 37'({cmd_diff[15:0], {`MSC_DIFF_SCALE{1'b0}}}) * 37'(gain_r);
  assign map_speed = 25'(map_prod >> `MSC_GAIN_FRAC) + 25'(min_speed_r);

  always_comb begin
    if (cmd_diff[16]) begin
      mag = min_speed_r;
    end else if (map_speed >= 25'(`MSC_SPEED_FULL)) begin
      mag = 14'(`MSC_SPEED_FULL);
    end else begin
      mag = map_speed[13:0];
    end
    mapped_target = dir_in ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
  end

  // ==========================================================================
  // Run state, target and fault handling
  // ==========================================================================
  logic retry_ok;
  assign retry_ok = (ctrl_r.mode != motor_speed_cmd_pkg::MODE_SERIAL);

  // Serial mode, and custom mapping in frequency or duty mode, leave both run and target to the command register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      target_r <= 16'sh0000;
    end else if (cmd_wr) begin
      run_r <= pwdata[`MSC_CMD_RUN_BIT];
      target_r <= $signed(pwdata[15:0]);
    end else if (pwm_tick && linear_mode) begin
      if (cmd_level > start_thr_r) begin
        run_r <= 1'b1;
      end else if (cmd_level < stop_thr_r) begin
        run_r <= 1'b0;
      end
      target_r <= mapped_target;
    end
  end

  // A fault event wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_r <= 1'b0;
      retry_left_r <= 8'h0;
      retry_wait_r <= 16'h0;
    end else if (fault_in) begin
      if (!fault_r) begin
        retry_wait_r <= retry_r.interval;
      end
      fault_r <= 1'b1;
    end else if (cmd_wr && pwdata[`MSC_CMD_CLEAR_BIT]) begin
      fault_r <= 1'b0;
      retry_left_r <= retry_r.count;
    end else if (retry_wr) begin
      retry_left_r <= pwdata[`MSC_RETRY_CNT_LSB +: 8];
    end else if (fault_r && retry_ok && pwm_tick && retry_left_r != 8'h0) begin
      if (retry_wait_r == 16'h0) begin
        fault_r <= 1'b0;
        retry_left_r <= retry_left_r - 8'h1;
      end else begin
        retry_wait_r <= retry_wait_r - 16'h1;
      end
    end
  end

  assign motor_run = run_r & ~fault_r;
  assign motor_fault = fault_r;
  assign target_speed_value = target_r;

  // ==========================================================================
  // Position pulse output
  // ==========================================================================
  logic [15:0] angle_d_r;
  logic signed [21:0] pg_acc_r;
  logic [21:0] pg_half;
  logic signed [21:0] pg_sum;
  logic pg_en;
  logic pg_en_d_r;
  logic signed [15:0] angle_delta;

  assign pg_half = 22'({2'b00, pg_step_r}) << `MSC_PG_HALF_SHIFT;
  assign angle_delta = $signed(rotor_angle - angle_d_r);
  assign pg_sum = pg_acc_r + 22'(angle_delta);
  assign pg_en = (pg_step_r != 14'h0) &
                 ((ctrl_r.sense != motor_speed_cmd_pkg::SENSE_LESS) | ctrl_r.pg_always |
                  motor_run);

  // A power-of-two half period starts the phase from the absolute angle, so edges land
  // on fixed rotor angles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_d_r <= 16'h0;
      pg_acc_r <= 22'sh0;
      pg_r <= 1'b0;
      pg_en_d_r <= 1'b0;
    end else if (pwm_tick) begin
      angle_d_r <= rotor_angle;
      pg_en_d_r <= pg_en;
      if (!pg_en) begin
        pg_r <= 1'b0;
      end else if (!pg_en_d_r) begin
        pg_acc_r <= $signed(22'(rotor_angle) & (pg_half - 22'h1));
        pg_r <= 1'b0;
      end else if (pg_sum >= $signed(pg_half)) begin
        pg_acc_r <= pg_sum - $signed(pg_half);
        pg_r <= ~pg_r;
      end else if (pg_sum < 22'sh0) begin
        pg_acc_r <= pg_sum + $signed(pg_half);
        pg_r <= ~pg_r;
      end else begin
        pg_acc_r <= pg_sum;
      end
    end
  end

  assign position_pulse_out = pg_r;

endmodule : motor_speed_command_input

`default_nettype wire

// ---- test/speed_cmd_source.sv ----
// Model of the external pulse command source.
`timescale 1ns/100ps
`default_nettype none
module speed_cmd_source (
  input wire logic pclk, // Clock.
  input wire logic en, // Source on.
  input wire logic [31:0] period, // Period in clocks.
  input wire logic [31:0] high, // High time in clocks.
  output logic pin // Command pin.
);
  logic [31:0] cnt = 32'h0;
  always @(posedge pclk) begin
    cnt <= (!en || cnt == period - 1) ? 32'h0 : cnt + 1;
  end
  // The pin idles low while the source is off.
  assign pin = en && cnt < high;
endmodule : speed_cmd_source
`default_nettype wire

// ---- test/motor_speed_cmd_sva.sv ----
// Port checker for the speed command front end.
`timescale 1ns/100ps
`default_nettype none
module motor_speed_cmd_chk #(
  parameter int ADC_W = 12
) (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [7:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Data.
  input wire logic [31:0] prdata, // Read data.
  input wire logic pready, // Ready.
  input wire logic pslverr, // Error.
  input wire logic pulse_speed_cmd_in, // Pin.
  input wire logic dir_in, // Direction.
  input wire logic [ADC_W-1:0] analog_sample_value, // Level.
  input wire logic pwm_tick, // Tick.
  input wire logic fault_in, // Fault.
  input wire logic [15:0] rotor_angle, // Angle.
  input wire logic motor_run, // Run.
  input wire logic signed [15:0] target_speed_value, // Target.
  input wire logic motor_fault, // Fault status.
  input wire logic position_pulse_out // Pulse.
);
  logic wr;
  logic calm;
  logic [4:0] ctl_q;
  logic [15:0] st_q;
  logic [15:0] sp_q;
  logic [13:0] step_q;
  logic [15:0] lvl;
  assign wr = psel && penable && pwrite;
  assign lvl = 16'(analog_sample_value);
  // An analog tick with no write and no fault, so only the thresholds decide.
  assign calm = ctl_q[1:0] == 2'h1 && pwm_tick && !wr && !fault_in && !motor_fault;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 5'h00;
      st_q <= 16'h0000;
      sp_q <= 16'h0000;
      step_q <= 14'h0000;
    end else if (wr) begin
      if (paddr == 8'h00) ctl_q <= pwdata[4:0];
      if (paddr == 8'h08) st_q <= pwdata[15:0];
      if (paddr == 8'h0c) sp_q <= pwdata[15:0];
      if (paddr == 8'h18) step_q <= pwdata[13:0];
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_cmd_target: assert property (wr && paddr == 8'h04
    |=> target_speed_value == $past(pwdata[15:0])) else $error("target not taken");
  a_cmd_run: assert property (wr && paddr == 8'h04 && !fault_in
    |=> motor_run == ($past(pwdata[16]) && !motor_fault)) else $error("run not taken");
  a_fault_stops: assert property (fault_in |=> motor_fault && !motor_run)
    else $error("fault did not stop");
  a_fault_holds: assert property (ctl_q[1:0] == 2'h0 && motor_fault
    && !(wr && paddr == 8'h04 && pwdata[17]) |=> motor_fault) else $error("fault lost");
  a_start_above: assert property (calm && lvl > st_q |=> motor_run)
    else $error("no start");
  a_stop_below: assert property (calm && lvl < sp_q |=> !motor_run)
    else $error("no stop");
  a_keep_between: assert property (calm && lvl >= sp_q && lvl <= st_q
    |=> motor_run == $past(motor_run)) else $error("run changed");
  a_pulse_tick: assert property ($changed(position_pulse_out) |-> $past(pwm_tick))
    else $error("pulse off tick");
  a_zero_step: assert property (!wr && step_q == 14'h0 && !position_pulse_out
    |=> !position_pulse_out) else $error("pulse with zero step");
  a_idle_pulse: assert property (!wr && ctl_q == 5'h00 && !motor_run
    && !position_pulse_out |=> !position_pulse_out) else $error("pulse while idle");
endmodule : motor_speed_cmd_chk
bind motor_speed_command_input motor_speed_cmd_chk #(.ADC_W(ADC_W)) i_motor_speed_cmd_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pulse_speed_cmd_in(pulse_speed_cmd_in), .dir_in(dir_in),
  .analog_sample_value(analog_sample_value), .pwm_tick(pwm_tick), .fault_in(fault_in),
  .rotor_angle(rotor_angle), .motor_run(motor_run), .target_speed_value(target_speed_value),
  .motor_fault(motor_fault), .position_pulse_out(position_pulse_out));
`default_nettype wire

// ---- test/motor_speed_command_input_tb.sv ----
// Self-checking bench for the speed command front end.
`timescale 1ns/100ps
`default_nettype none
module motor_speed_command_input_tb;
  localparam logic [32:0] all_m = 33'h1ffffffff;
  logic pclk, presetn, psel, penable, pwrite, tick_in, fault_in, dir_in, src_en;
  logic pready, pslverr, run, flt, pg, pin, pg_q;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] lvl;
  logic [15:0] angle, tgt;
  logic signed [15:0] tsv;
  logic [32:0] q_exp[$], q_msk[$];
  int n_fail, checks, cyc, n_tog, g, m, t0;
  logic [7:0] offs[11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
    8'h24, 8'h28};
  logic [11:0] lv[5] = '{12'd1200, 12'd800, 12'd400, 12'd800, 12'd4095};
  logic rn[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [31:0] pc[4] = '{32'h4, 32'h4, 32'h0, 32'h10};
  logic [31:0] ps[4] = '{32'd512, 32'd0, 32'd512, 32'd512};
  int pt[4] = '{4, 0, 0, 4};
  motor_speed_command_input #(.REFRESH_CYCLES(100), .TIMEOUT_CYCLES(100000))
    i_motor_speed_command_input (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_speed_cmd_in(pin), .dir_in(dir_in),
    .analog_sample_value(lvl), .pwm_tick(tick_in), .fault_in(fault_in), .rotor_angle(angle),
    .motor_run(run), .target_speed_value(tsv), .motor_fault(flt), .position_pulse_out(pg));
  speed_cmd_source i_speed_cmd_source (.pclk(pclk), .en(src_en), .period(32'd50000),
    .high(32'd15000), .pin(pin));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] k);
    q_exp.push_back(e & k);
    q_msk.push_back(k);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic tick(input int n);
    repeat (n) begin
      tick_in <= 1'b1;
      @(posedge pclk);
      tick_in <= 1'b0;
      @(posedge pclk);
    end
  endtask : tick
  task automatic hit();
    fault_in <= 1'b1;
    @(posedge pclk);
    fault_in <= 1'b0;
    @(posedge pclk);
  endtask : hit
  function automatic logic [32:0] sx(input logic [15:0] t);
    return {1'b0, {16{t[15]}}, t};
  endfunction : sx
  function automatic logic [15:0] tg(input int l, input logic d);
    int s;
    s = (l > 1000) ? m + (((l - 1000) * 32 * g) >> 12) : m;
    if (s > 16383) s = 16383;
    return d ? 16'(-s) : 16'(s);
  endfunction : tg
  // Read results are compared against the oldest queued expectation.
  always @(posedge pclk) begin
    cyc++;
    pg_q <= pg;
    if (pg !== pg_q) n_tog++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (q_msk.size() == 0) chk("extra", 33'h0, 33'h1);
      else chk("read", q_exp.pop_front(), {pslverr, prdata} & q_msk.pop_front());
    end
    if (cyc == 60000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, tick_in, fault_in, dir_in, src_en} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    lvl = 12'h000;
    angle = 16'h0000;
    void'($urandom(34536));
    g = 1000 + $urandom % 3000;
    m = $urandom % 2000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rd(offs[i], 33'h0, all_m);
    rd(8'h2c, 33'h100000000, all_m);
    tgt = 16'($urandom);
    wr(8'h04, {15'h0, 1'b1, tgt});
    rd(8'h20, sx(tgt), all_m);
    rd(8'h1c, 33'h1, 33'h7);
    hit();
    tick(6);
    rd(8'h1c, 33'h6, 33'h6);
    wr(8'h04, 32'h20000);
    rd(8'h1c, 33'h0, 33'h7);
    wr(8'h08, 32'd1000);
    wr(8'h0c, 32'd500);
    wr(8'h10, g);
    wr(8'h28, m);
    wr(8'h00, 32'h1);
    foreach (lv[i]) begin
      lvl <= lv[i];
      dir_in <= 1'($urandom);
      tick(1);
      rd(8'h1c, {32'h0, rn[i]}, 33'h1);
      tgt = tg(lv[i], dir_in);
      rd(8'h20, sx(tgt), all_m);
    end
    wr(8'h00, 32'h0);
    lvl <= 12'd100;
    tick(2);
    rd(8'h1c, 33'h1, 33'h1);
    rd(8'h20, sx(tgt), all_m);
    wr(8'h00, 32'h1);
    lvl <= 12'd1200;
    wr(8'h14, 32'h302);
    wr(8'h04, 32'h20000);
    hit();
    tick(3);
    rd(8'h1c, 33'h206, 33'hff06);
    tick(1);
    rd(8'h1c, 33'h100, 33'hff06);
    wr(8'h14, 32'h300);
    wr(8'h04, 32'h20000);
    hit();
    tick(8);
    rd(8'h1c, 33'h6, 33'hff06);
    wr(8'h04, 32'h20000);
    src_en <= 1'b1;
    wr(8'h08, 32'd2000);
    wr(8'h0c, 32'd1500);
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h2);
    repeat (50100) @(posedge pclk);
    tick(1);
    rd(8'h1c, 33'h1, 33'h7);
    wr(8'h08, 32'd400);
    wr(8'h0c, 32'd350);
    wr(8'h00, 32'h3);
    tick(1);
    rd(8'h1c, 33'h0, 33'h1);
    wr(8'h00, 32'h43);
    repeat (300) @(posedge pclk);
    rd(8'h24, {1'b0, 16'd300, 16'd10000}, all_m);
    src_en <= 1'b0;
    wr(8'h04, 32'h0);
    foreach (pc[i]) begin
      wr(8'h00, pc[i]);
      wr(8'h18, ps[i]);
      t0 = n_tog;
      for (int k = 1; k <= 32; k++) begin
        angle <= 16'(k * 4096);
        tick(1);
      end
      @(posedge pclk);
      chk("toggles", 33'(pt[i]), 33'(n_tog - t0));
    end
    end_sim();
  end
endmodule : motor_speed_command_input_tb
`default_nettype wire
